// File: logic/srpd_regs.sv
// How it works
// [RL1] bits 7..4 power down loop, regulator, osc, input
// [RL2] global bit powers lanes per disable mode
// [RL3] block bit kills frame ref and sync
// [RL4] delay bit powers down frame ref delay
// [RL5] host keeps delay powered during sync
// [RL6] bit 0 powers down pulse generator
// [RL7] enable bits select frame ref, even outputs
// [RL8] step count N gives exactly N steps
// [RL9] count write starts steps on enabled outputs
// [RL10] only register writes start an adjustment
// [RL11] host sets sync mode 3 before stepping
// [RL12] registers hold, read back, drive continuously
`timescale 1ns/1ps
`default_nettype none
`include "srpd_map.svh"

module srpd_regs
  import srpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [`SRPD_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [`SRPD_NUM_SR*`SRPD_DIS_MODE_W-1:0]
    per_output_disable_mode,
  output logic [7:0] reg_rdata,
  output logic first_loop_powerdown,
  output logic osc_regulator_powerdown,
  output logic internal_osc_powerdown,
  output logic reference_input_powerdown,
  output logic global_frame_ref_powerdown,
  output logic frame_ref_block_powerdown,
  output logic frame_ref_delay_powerdown,
  output logic frame_ref_pulser_powerdown,
  output logic frame_ref_sync_allowed,
  output logic [`SRPD_NUM_SR-1:0] frame_ref_lane_powerdown,
  output logic [7:0] dyn_delay_step,
  output logic dyn_delay_busy
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  srpd_top_t r;
  srpd_top_t nxt;
  logic wr_pwr;
  logic wr_en;
  logic wr_cnt;
  logic start_w;
  logic sr_gate;
  logic step_tick;

  assign wr_pwr = reg_wr_en && (reg_addr == `SRPD_OFS_PWR);
  assign wr_en = reg_wr_en && (reg_addr == `SRPD_OFS_DDLY_EN);
  assign wr_cnt = reg_wr_en && (reg_addr == `SRPD_OFS_STEP_CNT);
  // no pin or internal event reaches the sequencer start
  assign start_w = wr_cnt; // [RL10]

  always_comb begin
    nxt = r;
    if (wr_pwr) begin
      nxt.pwr = reg_wdata; // [RL1] [RL12]
    end
    if (wr_en) begin
      nxt.en = reg_wdata; // [RL7]
    end
    if (wr_cnt) begin
      nxt.cnt = reg_wdata; // [RL8]
    end
    nxt.sync_ok = !nxt.pwr[`SRPD_BIT_BLOCK]; // [RL3]
    // read sees the value before a same-cycle write
    if (reg_rd_en) begin
      unique case (reg_addr)
        `SRPD_OFS_PWR: nxt.rdata = r.pwr; // [RL12]
        `SRPD_OFS_DDLY_EN: nxt.rdata = r.en;
        `SRPD_OFS_STEP_CNT: nxt.rdata = r.cnt;
        default: nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r <= '{pwr: `SRPD_RST_PWR, en: `SRPD_RST_DDLY_EN,
             cnt: `SRPD_RST_STEP_CNT, rdata: 8'h00, sync_ok: 1'b1};
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // power-down outputs, straight from the stored bits
  // ----------------------------------------------------------------
  assign first_loop_powerdown = r.pwr[`SRPD_BIT_FIRST_LOOP]; // [RL1]
  assign osc_regulator_powerdown = r.pwr[`SRPD_BIT_OSC_REG];
  assign internal_osc_powerdown = r.pwr[`SRPD_BIT_INT_OSC];
  assign reference_input_powerdown = r.pwr[`SRPD_BIT_REF_IN];
  assign global_frame_ref_powerdown = r.pwr[`SRPD_BIT_GBL];
  assign frame_ref_block_powerdown = r.pwr[`SRPD_BIT_BLOCK];
  assign frame_ref_delay_powerdown = r.pwr[`SRPD_BIT_DELAY]; // [RL4]
  assign frame_ref_pulser_powerdown = r.pwr[`SRPD_BIT_PULSER]; // [RL6]
  assign frame_ref_sync_allowed = r.sync_ok;
  assign reg_rdata = r.rdata;

  // ----------------------------------------------------------------
  // per-lane frame ref power-down
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `SRPD_NUM_SR; i++) begin : g_lane
    srpd_lane_pd u_lane (
      .core_clk(core_clk),
      .nrst(nrst),
      .global_pd(r.pwr[`SRPD_BIT_GBL]), // [RL2]
      .block_pd(r.pwr[`SRPD_BIT_BLOCK]), // [RL3]
      .dis_mode(per_output_disable_mode[i*`SRPD_DIS_MODE_W +:
                                        `SRPD_DIS_MODE_W]),
      .lane_pd(frame_ref_lane_powerdown[i])
    );
  end

  // ----------------------------------------------------------------
  // dynamic delay stepping
  // ----------------------------------------------------------------
  // gate follows the next power bits so step and pd change together;
  // the sync mode itself is the host's job and is not checked here
  assign sr_gate = !(nxt.pwr[`SRPD_BIT_DELAY] |
                     nxt.pwr[`SRPD_BIT_BLOCK]); // [RL4]

  srpd_step_seq u_seq (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(start_w), // [RL9]
    .count(reg_wdata),
    .en_mask(r.en), // [RL7]
    .sr_gate(sr_gate),
    .step(dyn_delay_step),
    .tick(step_tick),
    .busy(dyn_delay_busy)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [8:0] tick_cnt_h;
  logic [7:0] last_n_h;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tick_cnt_h <= 9'h000;
      last_n_h <= 8'h00;
    end else if (start_w) begin
      tick_cnt_h <= 9'h000;
      last_n_h <= reg_wdata;
    end else if (step_tick) begin
      tick_cnt_h <= tick_cnt_h + 9'h001;
    end
  end

  property p_pwr_defaults;
    @(posedge core_clk)
    $rose(nrst) |-> ({first_loop_powerdown, osc_regulator_powerdown,
                      internal_osc_powerdown,
                      reference_input_powerdown} == 4'hE);
  endproperty
  a_pwr_defaults: assert property (p_pwr_defaults) // [RL1]
    else $error("power-down defaults wrong after reset");

  property p_pwr_write;
    @(posedge core_clk) disable iff (!nrst)
    wr_pwr |=> ##1 ({first_loop_powerdown, osc_regulator_powerdown,
                     internal_osc_powerdown, reference_input_powerdown,
                     global_frame_ref_powerdown, frame_ref_block_powerdown,
                     frame_ref_delay_powerdown,
                     frame_ref_pulser_powerdown} == $past(reg_wdata, 2))
               || $past(wr_pwr);
  endproperty
  a_pwr_write: assert property (p_pwr_write) // [RL12]
    else $error("power bits do not hold the written value");

  property p_gbl_lane;
    @(posedge core_clk) disable iff (!nrst)
    (global_frame_ref_powerdown &&
     per_output_disable_mode[1:0] != `SRPD_DIS_MODE_KEEP)
      |=> frame_ref_lane_powerdown[0];
  endproperty
  a_gbl_lane: assert property (p_gbl_lane) // [RL2]
    else $error("global power-down did not reach lane 0");

  property p_block;
    @(posedge core_clk) disable iff (!nrst)
    frame_ref_block_powerdown |-> !frame_ref_sync_allowed
      ##1 (frame_ref_lane_powerdown == 7'h7F);
  endproperty
  a_block: assert property (p_block) // [RL3]
    else $error("frame ref still usable while block powered down");

  property p_delay_pd;
    @(posedge core_clk) disable iff (!nrst)
    frame_ref_delay_powerdown |-> !dyn_delay_step[`SRPD_BIT_SR_DYN];
  endproperty
  a_delay_pd: assert property (p_delay_pd) // [RL4]
    else $error("frame ref stepped with delay powered down");

  property p_pulser;
    @(posedge core_clk) disable iff (!nrst)
    (wr_pwr && !reg_wdata[`SRPD_BIT_PULSER]) |=>
      !frame_ref_pulser_powerdown;
  endproperty
  a_pulser: assert property (p_pulser) // [RL6]
    else $error("pulse generator stays powered down after clear");

  property p_first_step;
    @(posedge core_clk) disable iff (!nrst)
    (start_w && reg_wdata != 8'h00) ##1 !start_w |=>
      (dyn_delay_step[6:0] == $past(r.en[6:0], 2)) && step_tick;
  endproperty
  a_first_step: assert property (p_first_step) // [RL7] [RL9]
    else $error("first step missing or on wrong outputs");

  property p_step_total;
    @(posedge core_clk) disable iff (!nrst)
    ($fell(dyn_delay_busy) && last_n_h != 8'h00 && !$past(start_w)) |->
      ((tick_cnt_h + {8'h00, step_tick}) == {1'b0, last_n_h});
  endproperty
  a_step_total: assert property (p_step_total) // [RL8]
    else $error("step count differs from the written value");

  property p_no_spont;
    @(posedge core_clk) disable iff (!nrst)
    (!dyn_delay_busy && !start_w) |=> (dyn_delay_step == 8'h00);
  endproperty
  a_no_spont: assert property (p_no_spont) // [RL10]
    else $error("step without a count write");

  property p_sync_follow;
    @(posedge core_clk) disable iff (!nrst)
    frame_ref_sync_allowed == !frame_ref_block_powerdown;
  endproperty
  a_sync_follow: assert property (p_sync_follow) // [RL3]
    else $error("sync permission does not follow block power-down");

  property p_read_pwr;
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd_en && reg_addr == `SRPD_OFS_PWR) |=>
      (reg_rdata == $past({first_loop_powerdown, osc_regulator_powerdown,
                           internal_osc_powerdown,
                           reference_input_powerdown,
                           global_frame_ref_powerdown,
                           frame_ref_block_powerdown,
                           frame_ref_delay_powerdown,
                           frame_ref_pulser_powerdown}));
  endproperty
  a_read_pwr: assert property (p_read_pwr) // [RL12]
    else $error("power register readback differs from its bits");

  property p_busy_start;
    @(posedge core_clk) disable iff (!nrst)
    (start_w && reg_wdata != 8'h00) |=> dyn_delay_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) // [RL9]
    else $error("count write did not start a run");

  property p_cancel;
    @(posedge core_clk) disable iff (!nrst)
    (start_w && reg_wdata == 8'h00) |=> !dyn_delay_busy;
  endproperty
  a_cancel: assert property (p_cancel) // [RL8]
    else $error("zero count left a run going");

  property p_lane_release;
    @(posedge core_clk) disable iff (!nrst)
    (!global_frame_ref_powerdown && !frame_ref_block_powerdown) |=>
      (frame_ref_lane_powerdown == 7'h00);
  endproperty
  a_lane_release: assert property (p_lane_release) // [RL2]
    else $error("lane stays powered down after release");

  property p_tick_gap;
    @(posedge core_clk) disable iff (!nrst)
    step_tick |=> !step_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) // [RL8]
    else $error("two step pulses in adjacent cycles");

  c_run: cover property (@(posedge core_clk) disable iff (!nrst)
    $fell(dyn_delay_busy) && last_n_h > 8'h02);
  c_restart: cover property (@(posedge core_clk) disable iff (!nrst)
    start_w && dyn_delay_busy);
  c_lane_pd: cover property (@(posedge core_clk) disable iff (!nrst)
    global_frame_ref_powerdown && frame_ref_lane_powerdown != 7'h00
    && !frame_ref_block_powerdown);
  c_sr_step: cover property (@(posedge core_clk) disable iff (!nrst)
    dyn_delay_step[`SRPD_BIT_SR_DYN]);
endmodule // srpd_regs

`default_nettype wire

// File: logic/srpd_map.svh
`ifndef SRPD_MAP_SVH
`define SRPD_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SRPD_ADDR_W 15
`define SRPD_OFS_PWR 15'h0140
`define SRPD_OFS_DDLY_EN 15'h0141
`define SRPD_OFS_STEP_CNT 15'h0142

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SRPD_RST_PWR 8'hE0
`define SRPD_RST_DDLY_EN 8'h00
`define SRPD_RST_STEP_CNT 8'h00

// ----------------------------------------------------------------
// power register fields
// ----------------------------------------------------------------
`define SRPD_BIT_FIRST_LOOP 7
`define SRPD_BIT_OSC_REG 6
`define SRPD_BIT_INT_OSC 5
`define SRPD_BIT_REF_IN 4
`define SRPD_BIT_GBL 3
`define SRPD_BIT_BLOCK 2
`define SRPD_BIT_DELAY 1
`define SRPD_BIT_PULSER 0

// ----------------------------------------------------------------
// dynamic delay
// ----------------------------------------------------------------
`define SRPD_BIT_SR_DYN 7
`define SRPD_NUM_SR 7
`define SRPD_DIS_MODE_W 2
`define SRPD_DIS_MODE_KEEP 2'h0
`define SRPD_STEP_PERIOD 8'h04

`endif

// File: logic/srpd_pkg.sv
`default_nettype none
`include "srpd_map.svh"

package srpd_pkg;

  typedef enum logic [1:0] {
    SRPD_IDLE,
    SRPD_STEP,
    SRPD_GAP
  } srpd_seq_st_t;

  typedef struct packed {
    srpd_seq_st_t st;
    logic [7:0] remain;
    logic [7:0] mask;
    logic [7:0] gap;
    logic [7:0] step;
    logic tick;
    logic busy;
  } srpd_seq_t;

  typedef struct packed {
    logic pd;
  } srpd_lane_t;

  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] en;
    logic [7:0] cnt;
    logic [7:0] rdata;
    logic sync_ok;
  } srpd_top_t;

endpackage

`default_nettype wire

// File: logic/srpd_lane_pd.sv
`timescale 1ns/1ps
`default_nettype none
`include "srpd_map.svh"

module srpd_lane_pd
  import srpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic global_pd,
  input wire logic block_pd,
  input wire logic [`SRPD_DIS_MODE_W-1:0] dis_mode,
  output logic lane_pd
);
  srpd_lane_t r;
  srpd_lane_t nxt;

  always_comb begin
    nxt = r;
    // one global bit fans out, each lane filtered by its own mode
    nxt.pd = block_pd |
             (global_pd && (dis_mode != `SRPD_DIS_MODE_KEEP)); // [RL2]
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r <= '{pd: 1'b0};
    end else begin
      r <= nxt;
    end
  end

  assign lane_pd = r.pd;
endmodule // srpd_lane_pd

`default_nettype wire

// File: logic/srpd_step_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "srpd_map.svh"

module srpd_step_seq
  import srpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic [7:0] en_mask,
  input wire logic sr_gate,
  output logic [7:0] step,
  output logic tick,
  output logic busy
);
  srpd_seq_t r;
  srpd_seq_t nxt;

  always_comb begin
    nxt = r;
    nxt.step = 8'h00;
    nxt.tick = 1'b0;
    unique case (r.st)
      SRPD_IDLE: nxt.st = SRPD_IDLE;
      SRPD_STEP: begin
        nxt.step = r.mask; // [RL9]
        // delay circuitry powered down: the frame ref lane gets no step
        nxt.step[`SRPD_BIT_SR_DYN] = r.mask[`SRPD_BIT_SR_DYN] & sr_gate;
        nxt.tick = 1'b1;
        nxt.remain = r.remain - 8'h01; // [RL8]
        if (r.remain == 8'h01) begin
          nxt.st = SRPD_IDLE;
        end else begin
          nxt.st = SRPD_GAP;
          nxt.gap = `SRPD_STEP_PERIOD - 8'h02;
        end
      end
      SRPD_GAP: begin
        if (r.gap == 8'h00) begin
          nxt.st = SRPD_STEP;
        end else begin
          nxt.gap = r.gap - 8'h01;
        end
      end
      default: nxt.st = SRPD_IDLE;
    endcase
    // a fresh write restarts; a zero count cancels any run
    if (start) begin
      // old run's pulse is dropped so the new count stays exact
      nxt.step = 8'h00;
      nxt.tick = 1'b0;
      nxt.remain = count;
      nxt.mask = en_mask;
      nxt.st = (count == 8'h00) ? SRPD_IDLE : SRPD_STEP; // [RL8]
    end
    nxt.busy = (nxt.st != SRPD_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r <= '{st: SRPD_IDLE, remain: 8'h00, mask: 8'h00, gap: 8'h00,
             step: 8'h00, tick: 1'b0, busy: 1'b0};
    end else begin
      r <= nxt;
    end
  end

  assign step = r.step;
  assign tick = r.tick;
  assign busy = r.busy;
endmodule // srpd_step_seq

`default_nettype wire

// File: verification/sysref_powerdown_dyn_delay_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "srpd_map.svh"

module sysref_powerdown_dyn_delay_regs_tb
  import srpd_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic core_clk;
  logic nrst;
  logic [`SRPD_ADDR_W-1:0] reg_addr;
  logic reg_wr_en;
  logic [7:0] reg_wdata;
  logic reg_rd_en;
  logic [`SRPD_NUM_SR*`SRPD_DIS_MODE_W-1:0] dis_mode;
  logic [7:0] reg_rdata;
  logic [7:0] pwr_o;
  logic sync_ok;
  logic [`SRPD_NUM_SR-1:0] lane_pd;
  logic [7:0] step;
  logic busy;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  srpd_regs dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en),
    .per_output_disable_mode(dis_mode),
    .reg_rdata(reg_rdata),
    .first_loop_powerdown(pwr_o[7]),
    .osc_regulator_powerdown(pwr_o[6]),
    .internal_osc_powerdown(pwr_o[5]),
    .reference_input_powerdown(pwr_o[4]),
    .global_frame_ref_powerdown(pwr_o[3]),
    .frame_ref_block_powerdown(pwr_o[2]),
    .frame_ref_delay_powerdown(pwr_o[1]),
    .frame_ref_pulser_powerdown(pwr_o[0]),
    .frame_ref_sync_allowed(sync_ok),
    .frame_ref_lane_powerdown(lane_pd),
    .dyn_delay_step(step),
    .dyn_delay_busy(busy)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered at a falling edge; idle cycle at the end avoids
  // re-raising the strobe in the same time step
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk(reg_rdata, exp);
    @(negedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(pwr_o, 8'hE0);
    chk({7'h00, sync_ok}, 8'h01);
    chk({busy, step[6:0]}, 8'h00);
    rd_chk(`SRPD_OFS_PWR, 8'hE0);
    rd_chk(`SRPD_OFS_DDLY_EN, 8'h00);
    rd_chk(`SRPD_OFS_STEP_CNT, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_power();
    logic [7:0] p;
    for (int i = 0; i <= 8; i++) begin
      p = (i < 8) ? (8'h01 << i) : 8'h00;
      wr(`SRPD_OFS_PWR, p);
      chk(pwr_o, p);
      chk({7'h00, sync_ok}, {7'h00, ~p[2]});
      rd_chk(`SRPD_OFS_PWR, p);
    end
    // unmapped place: write ignored, reads zero
    wr(15'h0143, 8'hFF);
    rd_chk(`SRPD_OFS_PWR, 8'h00);
    rd_chk(15'h0143, 8'h00);
    $display("test power done");
  endtask

  task automatic t_lanes();
    // lane i takes mode i mod 4; mode 0 keeps the lane up
    for (int i = 0; i < `SRPD_NUM_SR; i++) begin
      dis_mode[2*i +: 2] = 2'(i % 4);
    end
    wr(`SRPD_OFS_PWR, 8'h08);
    @(negedge core_clk);
    chk({1'b0, lane_pd}, 8'h6E);
    wr(`SRPD_OFS_PWR, 8'h04);
    @(negedge core_clk);
    chk({1'b0, lane_pd}, 8'h7F);
    wr(`SRPD_OFS_PWR, 8'h00);
    @(negedge core_clk);
    chk({1'b0, lane_pd}, 8'h00);
    $display("test lanes done");
  endtask

  task automatic t_no_spur();
    int seen;
    seen = 0;
    wr(`SRPD_OFS_DDLY_EN, 8'hFF);
    dis_mode = '1;
    wr(`SRPD_OFS_PWR, 8'h08);
    rd_chk(`SRPD_OFS_STEP_CNT, 8'h00);
    for (int i = 0; i < 20; i++) begin
      if (step !== 8'h00 || busy !== 1'b0) seen++;
      @(negedge core_clk);
    end
    chk(8'(seen), 8'h00);
    wr(`SRPD_OFS_PWR, 8'h00);
    $display("test no spurious start done");
  endtask

  task automatic t_steps(input logic [7:0] en, input logic [7:0] pwr,
                         input logic [7:0] n, input logic [7:0] exp);
    int pulses;
    int bad;
    pulses = 0;
    bad = 0;
    wr(`SRPD_OFS_PWR, pwr);
    wr(`SRPD_OFS_DDLY_EN, en);
    wr(`SRPD_OFS_STEP_CNT, n);
    chk({7'h00, busy}, {7'h00, n > 8'h01});
    for (int i = 0; i < n * `SRPD_STEP_PERIOD + 8; i++) begin
      if (step !== 8'h00) begin
        pulses++;
        if (step !== exp) bad++;
      end
      @(negedge core_clk);
    end
    chk(8'(pulses), (exp == 8'h00) ? 8'h00 : n);
    chk(8'(bad), 8'h00);
    chk({7'h00, busy}, 8'h00);
    rd_chk(`SRPD_OFS_STEP_CNT, n);
    rd_chk(`SRPD_OFS_DDLY_EN, en);
    $display("test steps en %h count %h done", en, n);
  endtask

  // a second count write mid-run restarts with the new count
  task automatic t_restart();
    int pulses;
    pulses = 0;
    wr(`SRPD_OFS_PWR, 8'h00);
    wr(`SRPD_OFS_DDLY_EN, 8'h01);
    wr(`SRPD_OFS_STEP_CNT, 8'h03);
    wr(`SRPD_OFS_STEP_CNT, 8'h02);
    for (int i = 0; i < 16; i++) begin
      if (step !== 8'h00) pulses++;
      @(negedge core_clk);
    end
    chk(8'(pulses), 8'h02);
    $display("test restart done");
  endtask

  // ----------------------------------------------------------------
  // closing and hang guard
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      $display("Error at %0t: timeout after %h cycles", $time, cycles);
      complete_run();
    end
  end

  initial begin
    nrst = 1'b0;
    reg_addr = '0;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    dis_mode = '0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    t_reset();
    t_power();
    t_lanes();
    t_no_spur();
    t_steps(8'h05, 8'h00, 8'h02, 8'h05);
    t_steps(8'h85, 8'h02, 8'h03, 8'h05);
    t_steps(8'h85, 8'h04, 8'h01, 8'h05);
    t_steps(8'h80, 8'h00, 8'h01, 8'h80);
    t_steps(8'h00, 8'h00, 8'h03, 8'h00);
    t_steps(8'h40, 8'h00, 8'h00, 8'h00);
    t_steps(8'hFF, 8'h00, 8'hFF, 8'hFF);
    t_restart();
    complete_run();
  end
endmodule // sysref_powerdown_dyn_delay_regs_tb

`default_nettype wire
